// ---- sipo_buf2.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sipo_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Filling side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // Draining side
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  // Only the two-entry layout is built
  if (DEPTH != 2) begin : g_depth_check
    $error("sipo_buf2 supports exactly two entries");
  end

  // ==========================================
  // Storage
  logic [W-1:0] head_reg;
  logic [W-1:0] head_next;
  logic [W-1:0] tail_reg;
  logic [W-1:0] tail_next;
  logic [1:0]   count_reg;
  logic [1:0]   count_next;
  logic         push;
  logic         pop;

  always_comb begin
    push       = in_valid_i && in_ready_o;
    pop        = out_valid_o && out_ready_i;
    head_next  = head_reg;
    tail_next  = tail_reg;
    count_next = count_reg;
    case ({push, pop})
      2'b10: begin
        if (count_reg == 2'h0) begin
          head_next = in_data_i;
        end else begin
          tail_next = in_data_i;
        end
        count_next = count_reg + 2'h1;
      end
      2'b01: begin
        head_next  = tail_reg;
        count_next = count_reg - 2'h1;
      end
      2'b11: begin
        // Simultaneous push and pop keeps the level constant
        if (count_reg == 2'h1) begin
          head_next = in_data_i;
        end else begin
          head_next = tail_reg;
          tail_next = in_data_i;
        end
      end
      default: begin
        count_next = count_reg;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_reg    <= '0;
      tail_reg    <= '0;
      count_reg   <= 2'h0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
    end else begin
      head_reg    <= head_next;
      tail_reg    <= tail_next;
      count_reg   <= count_next;
      out_valid_o <= (count_next != 2'h0);
      in_ready_o  <= (count_next != 2'h2);
    end
  end

  assign out_data_o = head_reg;

endmodule
`default_nettype wire

// ---- sipo_host.sv ----
// Host model driving the shift, storage and serial pins
`timescale 1ns/1ps
`default_nettype none
module sipo_host (
  input  wire logic clk_i,
  output logic      shift_clock_o,
  output logic      storage_clock_o,
  output logic      serial_in_o
);
  // ==========
  initial begin
    shift_clock_o = 1'b0;
    storage_clock_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data turns over after its hold, never left looking valid
  task automatic pulse(input logic sh, input logic st, input logic d);
    serial_in_o = d;
    wt(3);
    shift_clock_o = sh;
    storage_clock_o = st;
    wt(2);
    serial_in_o = ~d;
    wt(1);
    shift_clock_o = 1'b0;
    storage_clock_o = 1'b0;
    wt(3);
  endtask
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) pulse(1'b1, 1'b0, b[i]);
  endtask
endmodule
`default_nettype wire

// ---- sipo_latch.sv ----
// Serial-in parallel-out shift register with storage register and tri-state outputs
//
// Operation
// - Eight shift stages feed eight storage flops
// - Storage drives eight outputs, high, low, off
// - Shift and storage each have own clock
// - Rising edges: shift in serial, copy store
// - Low clear empties shift stages, storage untouched
// - Serial input in, last stage cascades out
// - Tied clocks: storage one pulse behind
`timescale 1ns/1ps
`default_nettype none
module sipo_latch
  import sipo_pkg::*;
#(
  parameter int DATA_W = sipo_pkg::SIPO_DATA_W
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  // Pins from the controller
  input  wire logic                        shift_clock_i,
  input  wire logic                        storage_clock_i,
  input  wire logic                        serial_in_i,
  input  wire logic                        shift_clear_n_i,
  input  wire logic                        output_enable_n_i,
  // Parallel outputs, three-state
  output logic [DATA_W-1:0]                parallel_out_o,
  output logic [DATA_W-1:0]                parallel_oe_o,
  // Cascade output
  output logic                             serial_cascade_out_o,
  // Stream of captured bytes
  output sipo_pkg::sipo_word_s             word_o,
  output logic                             word_valid_o,
  input  wire logic                        word_ready_i,
  output logic                             capture_ready_o
);

  // Shift path is built for eight stages only
  if (DATA_W != SIPO_DATA_W) begin : g_width_check
    $error("sipo_latch supports only an 8-bit shift path");
  end

  // ==========================================
  // Reset release
  // Asserts at once, releases two edges later so no flop leaves reset mid-edge
  logic [1:0] rst_sync_reg;
  logic [1:0] rst_sync_next;
  logic       rst_n;

  always_comb begin
    rst_sync_next = {rst_sync_reg[0], 1'b1};
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= SIPO_SYNC_RST;
    end else begin
      rst_sync_reg <= rst_sync_next;
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ==========================================
  // Pin synchronisers
  // First stage is read only by the second
  sipo_pins_s pins_s1_reg;
  sipo_pins_s pins_s1_next;
  sipo_pins_s pins_s2_reg;
  sipo_pins_s pins_s2_next;
  sipo_pins_s pins_prev_reg;
  sipo_pins_s pins_prev_next;
  sipo_pins_s pins_raw;

  assign pins_raw = '{shift_clock: shift_clock_i, storage_clock: storage_clock_i, serial_in: serial_in_i};

  always_comb begin
    pins_s1_next   = pins_raw;
    pins_s2_next   = pins_s1_reg;
    pins_prev_next = pins_s2_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1_reg   <= '0;
      pins_s2_reg   <= '0;
      pins_prev_reg <= '0;
    end else begin
      pins_s1_reg   <= pins_s1_next;
      pins_s2_reg   <= pins_s2_next;
      pins_prev_reg <= pins_prev_next;
    end
  end

  // ==========================================
  // Clear synchroniser
  // Reset value holds the clear on until the pin has been seen
  logic [1:0] clr_n_sync_reg;
  logic [1:0] clr_n_sync_next;

  always_comb begin
    clr_n_sync_next = {clr_n_sync_reg[0], shift_clear_n_i};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clr_n_sync_reg <= SIPO_CLRN_RST;
    end else begin
      clr_n_sync_reg <= clr_n_sync_next;
    end
  end

  // ==========================================
  // Enable synchroniser
  // Reset value keeps the outputs floating until the pin has been seen
  logic [1:0] oe_n_sync_reg;
  logic [1:0] oe_n_sync_next;

  always_comb begin
    oe_n_sync_next = {oe_n_sync_reg[0], output_enable_n_i};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_sync_reg <= SIPO_OEN_RST;
    end else begin
      oe_n_sync_reg <= oe_n_sync_next;
    end
  end

  // ==========================================
  // Edge detection
  // Rising edges only; falling edges do nothing
  logic shift_rise;
  logic store_rise;
  logic clear_act;

  always_comb begin
    shift_rise = pins_s2_reg.shift_clock && !pins_prev_reg.shift_clock;
    store_rise = pins_s2_reg.storage_clock && !pins_prev_reg.storage_clock;
    clear_act  = !clr_n_sync_reg[1];
  end

  // ==========================================
  // Shift and storage registers
  logic [DATA_W-1:0] shift_reg;
  logic [DATA_W-1:0] shift_next;
  logic [DATA_W-1:0] store_reg;
  logic [DATA_W-1:0] store_next;
  logic [DATA_W-1:0] capture_word;

  always_comb begin
    shift_next   = shift_reg;
    store_next   = store_reg;
    // A clear already seen empties what a storage edge in that cycle takes
    capture_word = clear_act ? SIPO_SHIFT_RST : shift_reg;
    if (clear_act) begin
      // Clear overrides any shift edge in the same cycle
      shift_next = SIPO_SHIFT_RST;
    end else if (shift_rise) begin
      shift_next = {shift_reg[DATA_W-2:0], pins_s2_reg.serial_in};
    end
    if (store_rise) begin
      // Old shift value taken, so tied clocks lag by one pulse
      store_next = capture_word;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= SIPO_SHIFT_RST;
      store_reg <= SIPO_STORE_RST;
    end else begin
      shift_reg <= shift_next;
      store_reg <= store_next;
    end
  end

  // ==========================================
  // Output enable
  // Enable only gates the drivers; storage keeps its value
  logic [DATA_W-1:0] oe_reg;
  logic [DATA_W-1:0] oe_next;

  always_comb begin
    oe_next = {DATA_W{!oe_n_sync_reg[1]}};
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg <= '0;
    end else begin
      oe_reg <= oe_next;
    end
  end

  // ==========================================
  // Outputs
  logic buf_in_ready;

  assign parallel_out_o       = store_reg;
  assign parallel_oe_o        = oe_reg;
  assign serial_cascade_out_o = shift_reg[DATA_W-1];
  assign capture_ready_o      = buf_in_ready;

  // ==========================================
  // Capture stream
  // Pins cannot be stalled; a capture while full is dropped, seen on capture_ready_o
  logic [DATA_W-1:0] buf_out_data;

  sipo_buf2 #(
    .W     (DATA_W),
    .DEPTH (SIPO_BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_data_i   (capture_word),
    .in_valid_i  (store_rise),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_out_data),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i)
  );

  assign word_o = '{data: buf_out_data};

endmodule
`default_nettype wire

// ---- sipo_latch_checker.sv ----
// Port assertions for the latch
`timescale 1ns/1ps
`default_nettype none
module sipo_latch_checker
  import sipo_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic              clk_i, nrst_i, shift_clock_i, storage_clock_i, serial_in_i,
  input wire logic              shift_clear_n_i, output_enable_n_i, word_ready_i,
  input wire logic [DATA_W-1:0] parallel_out_o, parallel_oe_o,
  input wire logic              serial_cascade_out_o, word_valid_o, capture_ready_o,
  input wire sipo_pkg::sipo_word_s word_o
);
  import sipo_pkg::*;
  // ==========
  // Margins cover the three-edge pin sync
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_oe; !output_enable_n_i [*8] |-> parallel_oe_o == {DATA_W{1'b1}}; endproperty
  a_oe: assert property (p_oe) else $error("outputs not driven");
  property p_hiz; output_enable_n_i [*5] |-> parallel_oe_o == '0; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not floated");
  property p_all; parallel_oe_o == '0 || &parallel_oe_o; endproperty
  a_all: assert property (p_all) else $error("enables split");
  property p_clr; !shift_clear_n_i [*5] |-> !serial_cascade_out_o; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_sh; (shift_clear_n_i && $stable(shift_clock_i)) [*5] |-> $stable(serial_cascade_out_o); endproperty
  a_sh: assert property (p_sh) else $error("shift without edge");
  property p_st; $stable(storage_clock_i) [*6] |-> $stable(parallel_out_o); endproperty
  a_st: assert property (p_st) else $error("store without edge");
  property p_hold; word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o); endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_full; !capture_ready_o |-> word_valid_o; endproperty
  a_full: assert property (p_full) else $error("full yet empty");
endmodule
bind sipo_latch sipo_latch_checker #(.DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .shift_clock_i(shift_clock_i), .storage_clock_i(storage_clock_i), .serial_in_i(serial_in_i),
  .shift_clear_n_i(shift_clear_n_i), .output_enable_n_i(output_enable_n_i), .word_ready_i(word_ready_i),
  .parallel_out_o(parallel_out_o), .parallel_oe_o(parallel_oe_o), .serial_cascade_out_o(serial_cascade_out_o),
  .word_valid_o(word_valid_o), .capture_ready_o(capture_ready_o), .word_o(word_o));
`default_nettype wire

// ---- sipo_pkg.sv ----
// Shared constants and types for the serial-in parallel-out latch
package sipo_pkg;

  // ==========================================
  // Widths and reset values
  localparam int          SIPO_DATA_W     = 8;
  localparam int          SIPO_SYNC_W     = 2;
  localparam logic [7:0]  SIPO_SHIFT_RST  = 8'h00;
  localparam logic [7:0]  SIPO_STORE_RST  = 8'h00;
  localparam logic [1:0]  SIPO_SYNC_RST   = 2'h0;
  localparam logic [1:0]  SIPO_OEN_RST    = 2'h3;
  localparam logic [1:0]  SIPO_CLRN_RST   = 2'h0;
  localparam int          SIPO_BUF_DEPTH  = 2;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic [SIPO_DATA_W-1:0] data;
  } sipo_word_s;

  typedef struct packed {
    logic shift_clock;
    logic storage_clock;
    logic serial_in;
  } sipo_pins_s;

endpackage

// ---- tb.sv ----
// Self-checking bench for the latch
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sipo_pkg::*;
  typedef struct { logic [7:0] b; logic oen; logic rdy; } sipo_row_s;
  logic       clk_i, nrst_i, sck, stck, sin, clr_n, oen, rdy, casc, wvalid, cap_rdy;
  logic [7:0] pout, poe;
  sipo_word_s word;
  int         failures, cmp_count;
  sipo_row_s  rows[4] = '{'{8'hA5, 1'b0, 1'b1}, '{8'h01, 1'b0, 1'b0}, '{8'h80, 1'b1, 1'b1}, '{8'hFF, 1'b0, 1'b0}};
  sipo_host u_host (.clk_i(clk_i), .shift_clock_o(sck), .storage_clock_o(stck), .serial_in_o(sin));
  sipo_latch u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .shift_clock_i(sck), .storage_clock_i(stck),
    .serial_in_i(sin), .shift_clear_n_i(clr_n), .output_enable_n_i(oen), .parallel_out_o(pout),
    .parallel_oe_o(poe), .serial_cascade_out_o(casc), .word_o(word), .word_valid_o(wvalid),
    .word_ready_i(rdy), .capture_ready_o(cap_rdy));
  // ==========
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    final_report();
  end
  initial begin
    nrst_i = 1'b0;
    clr_n = 1'b1;
    oen = 1'b0;
    rdy = 1'b1;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    u_host.wt(6);
    for (int i = 0; i < 4; i++) begin
      oen = rows[i].oen;
      rdy = rows[i].rdy;
      u_host.send(rows[i].b);
      chk({7'h0, casc}, {7'h0, rows[i].b[7]});
      u_host.pulse(1'b0, 1'b1, 1'b0);
      chk(pout, rows[i].b);
      chk(poe, {8{~rows[i].oen}});
      chk({7'h0, wvalid}, {7'h0, ~rows[i].rdy});
      if (!rows[i].rdy) chk(word.data, rows[i].b);
    end
    rdy = 1'b1;
    u_host.send(8'hC3);
    clr_n = 1'b0;
    u_host.wt(5);
    chk({7'h0, casc}, 8'h00);
    chk(pout, 8'hFF);
    clr_n = 1'b1;
    u_host.pulse(1'b0, 1'b1, 1'b0);
    chk(pout, 8'h00);
    u_host.send(8'h5A);
    u_host.pulse(1'b1, 1'b1, 1'b1);
    chk(pout, 8'h5A);
    // Stalled sink: third capture must be dropped, not overwrite
    rdy = 1'b0;
    u_host.pulse(1'b1, 1'b1, 1'b0);
    u_host.pulse(1'b1, 1'b1, 1'b1);
    chk({7'h0, cap_rdy}, 8'h00);
    u_host.pulse(1'b1, 1'b1, 1'b0);
    chk(pout, 8'hD5);
    chk(word.data, 8'hB5);
    rdy = 1'b1;
    u_host.wt(1);
    chk(word.data, 8'h6A);
    u_host.wt(1);
    chk({7'h0, wvalid}, 8'h00);
    // Mid-run reset with a word queued and outputs driven
    rdy = 1'b0;
    u_host.pulse(1'b0, 1'b1, 1'b0);
    chk(pout, 8'hAA);
    chk({7'h0, wvalid}, 8'h01);
    nrst_i = 1'b0;
    u_host.wt(2);
    chk(pout, 8'h00);
    chk(poe, 8'h00);
    chk({7'h0, casc}, 8'h00);
    chk({6'h0, wvalid, cap_rdy}, 8'h01);
    nrst_i = 1'b1;
    u_host.wt(2);
    chk(pout, 8'h00);
    chk({6'h0, wvalid, cap_rdy}, 8'h01);
    rdy = 1'b1;
    u_host.wt(4);
    u_host.send(8'hC3);
    chk({7'h0, casc}, 8'h01);
    u_host.pulse(1'b0, 1'b1, 1'b0);
    chk(pout, 8'hC3);
    chk(poe, 8'hFF);
    final_report();
  end
endmodule
`default_nettype wire
